// [src/qdrs_pkg.sv]
// Package with register map, field layouts and carrier types of the queued DMA read block.
package qdrs_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] OFF_ERR_FEAT = 8'h00;  // Read error_flags, write length.
  localparam logic [7:0] OFF_SECCNT   = 8'h04;
  localparam logic [7:0] OFF_SECNUM   = 8'h08;
  localparam logic [7:0] OFF_CYLLO    = 8'h0c;
  localparam logic [7:0] OFF_CYLHI    = 8'h10;
  localparam logic [7:0] OFF_DEVHEAD  = 8'h14;
  localparam logic [7:0] OFF_STAT_CMD = 8'h18;  // Read status_flags, write command.
  localparam logic [7:0] OFF_CTRL     = 8'h1c;
  localparam logic [7:0] OFF_TAGMAP   = 8'h20;

  // Command code of the queued DMA read.
  localparam logic [7:0] CMD_READ_DMA_QUEUED = 8'hc7;

  // Sector count field layout.
  localparam int SC_TAG_LSB = 3;
  localparam int SC_REL_BIT = 2;
  localparam int SC_IO_BIT  = 1;
  localparam int SC_CD_BIT  = 0;

  // Device/head field layout.
  localparam int DH_LBA_BIT = 6;
  localparam int DH_DEV_BIT = 4;

  // Control register bit positions.
  localparam int CTRL_QUEUING     = 0;
  localparam int CTRL_OVERLAP_INT = 1;
  localparam int CTRL_SUPPORTED   = 2;
  localparam int CTRL_GEOM_BAD    = 3;
  localparam int CTRL_RANGE_ABORT = 4;

  // Reset values.
  localparam logic [7:0] RST_CTRL   = 8'h07;
  localparam logic [7:0] RST_STATUS = 8'h40;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Error register image, bit 7 down to bit 0.
  typedef struct packed {
    logic interface_crc_error;
    logic uncorrectable_data;
    logic media_changed;
    logic address_not_found;
    logic media_change_request;
    logic command_aborted;
    logic no_media;
    logic obsolete;
  } qdrs_err_t;

  // Events from the media engine, all one-cycle pulses except the levels noted.
  typedef struct packed {
    logic       release_bus;   // Engine releases the bus before data.
    logic       complete;      // All data moved without error.
    logic       fail;          // Unrecoverable error, command ends.
    logic       other_ready;   // Level: another queued command awaits service.
    logic       prepared;      // Level: released command is ready for service.
    logic [4:0] tag;           // Tag of the command the event concerns.
  } qdrs_evt_t;

  // Cause of a failure, valid with the fail pulse.
  typedef struct packed {
    logic        ultra_dma;
    logic        crc_error;
    logic        udma_error;
    logic        uncorrectable;
    logic        not_found;
    logic        out_of_range;
    logic        fault;
    logic        unable;
    logic [27:0] fail_addr;
  } qdrs_cause_t;

  // Command handed to the media engine.
  typedef struct packed {
    logic        lba_mode;
    logic [27:0] start_addr;
    logic [8:0]  sectors;
    logic [4:0]  tag;
  } qdrs_cmd_t;

  localparam logic [8:0] FULL_LENGTH = 9'h100;

endpackage

// [src/qdrs_top.sv]
// Task-file command interpreter for the queued DMA read, with an AXI4-Lite register slave.
//
// Behaviour
// - Command code C7h starts a queued DMA read; unsupported, it aborts.
// - Length comes from the length register; 00h means 256 sectors.
// - With queuing, the tag is sector count bits 7 to 3.
// - Cylinder high is cylinder bits 15:8 or linear bits 23:16.
// - Device/head bit 6 picks linear mode; bits 3:0 are head or bits 27:24.
// - On release: released flag one, direction and command-phase flags zero.
// - On release the tag field shows the released tag, or zeros without queuing.
// - On release: busy, fault, data request, error clear; ready set.
// - Release service flag: another command ready or this one prepared.
// - Error-free completion writes 00h to the error register.
// - Completion shows the tag, released flag zero, direction and phase one.
// - Successful completion clears busy, fault, data request, error; sets ready.
// - At completion or error, service flag shows another command ready.
// - Abort when overlap interrupt disabled or queued tag invalid.
// - Unrecoverable error ends command, loads failing address, aborts queue.
// - Interface CRC bit set on a CRC error during Ultra DMA only.
// - Uncorrectable bit on bad data; no-media bit when media absent.
// - Media-changed bit reported, then internal change state cleared.
// - Address-not-found on missing address, bad geometry, or range without abort.
// - Media-change-request set on detection; cleared only by a media access.
// - Abort bit for unsupported command, Ultra DMA errors, range without not-found.
// - Error end: busy and request clear, ready set, fault, error summary.
// - Device select bit keeps showing the selected device.
//
// Local design decisions: the address map and register access over AXI4-Lite.
module qdrs_top (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_resetn,
  // AXI4-Lite slave.
  input  wire logic [7:0]           i_s_awaddr,
  input  wire logic                 i_s_awvalid,
  output logic                      o_s_awready,
  input  wire logic [31:0]          i_s_wdata,
  input  wire logic [3:0]           i_s_wstrb,
  input  wire logic                 i_s_wvalid,
  output logic                      o_s_wready,
  output logic [1:0]                o_s_bresp,
  output logic                      o_s_bvalid,
  input  wire logic                 i_s_bready,
  input  wire logic [7:0]           i_s_araddr,
  input  wire logic                 i_s_arvalid,
  output logic                      o_s_arready,
  output logic [31:0]               o_s_rdata,
  output logic [1:0]                o_s_rresp,
  output logic                      o_s_rvalid,
  input  wire logic                 i_s_rready,
  // Media engine side.
  input  wire qdrs_pkg::qdrs_evt_t   i_evt,
  input  wire qdrs_pkg::qdrs_cause_t i_cause,
  input  wire logic                 i_media_change_seen,
  input  wire logic                 i_media_change_req,
  input  wire logic                 i_no_media,
  output qdrs_pkg::qdrs_cmd_t        o_cmd,
  output logic                      o_cmd_start,
  output logic                      o_queue_abort,
  output logic                      o_busy
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY
  } qdrs_state_t;

  // Packs the status byte; bits 2 and 1 are unused and read zero.
  function automatic logic [7:0] status_byte(input logic device_busy_flag, input logic device_ready_flag,
                                             input logic df, input logic service_pending,
                                             input logic data_request_flag, input logic err);
    status_byte = {device_busy_flag, device_ready_flag, df, service_pending, data_request_flag, 2'h0, err};
  endfunction

  // Packs the sector count image from a tag and the three phase flags.
  function automatic logic [7:0] seccnt_byte(input logic [4:0] tag, input logic bus_released_flag,
                                             input logic io, input logic cd);
    seccnt_byte = {tag, bus_released_flag, io, cd};
  endfunction

  qdrs_state_t        state;
  logic [7:0]         length_reg;
  logic [7:0]         sector_count_tag;
  logic [7:0]         sector_number_lba_low;
  logic [7:0]         cylinder_low_lba_mid;
  logic [7:0]         cylinder_high_lba_high;
  logic [7:0]         device_head_select;
  qdrs_pkg::qdrs_err_t error_flags;
  logic [7:0]         status_flags;
  logic [7:0]         ctrl;
  logic [31:0]        tag_map;
  logic               media_change_state;
  logic               media_change_pending;
  logic [7:0]         aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic               wr_fire;
  logic               wr_lane;
  logic               wr_busy_ok;
  logic               cmd_write;
  logic               cmd_valid;
  logic               cmd_abort;
  logic [4:0]         host_tag;
  logic [4:0]         report_tag;
  logic               queuing;
  logic               addr_range_abort;
  logic               fail_abort;
  logic               fail_address_not_found;
  qdrs_pkg::qdrs_err_t next_err;

  assign queuing  = ctrl[qdrs_pkg::CTRL_QUEUING];
  assign host_tag = sector_count_tag[7:qdrs_pkg::SC_TAG_LSB];
  // Without queuing the tag field is reported as zeros.
  assign report_tag = queuing ? i_evt.tag : 5'h00;

  // A write is performed once both address and data are held and no answer is pending.
  assign wr_fire = ~o_s_awready & ~o_s_wready & ~o_s_bvalid;
  assign wr_lane = wr_fire & w_strb[0];
  // Task-file writes while busy are dropped so the image stays coherent.
  assign wr_busy_ok = wr_lane & (state == ST_IDLE);
  assign cmd_write  = wr_busy_ok & (aw_addr == qdrs_pkg::OFF_STAT_CMD);

  // Command acceptance checks in one place.
  always_comb begin
    cmd_valid = 1'b0;
    cmd_abort = 1'b0;
    if (cmd_write) begin
      if ((w_data[7:0] != qdrs_pkg::CMD_READ_DMA_QUEUED) ||
          !ctrl[qdrs_pkg::CTRL_SUPPORTED]) begin
        cmd_abort = 1'b1;
      end else if (!ctrl[qdrs_pkg::CTRL_OVERLAP_INT]) begin
        cmd_abort = 1'b1;
      end else if (queuing && tag_map[host_tag]) begin
        cmd_abort = 1'b1;
      end else begin
        cmd_valid = 1'b1;
      end
    end
  end

  // Out-of-range requests report either abort or not-found, never neither.
  assign addr_range_abort = i_cause.out_of_range & ctrl[qdrs_pkg::CTRL_RANGE_ABORT];
  assign fail_abort = (i_cause.ultra_dma & (i_cause.udma_error | i_cause.crc_error)) |
                      i_cause.unable | addr_range_abort;
  assign fail_address_not_found  = i_cause.not_found |
                      (ctrl[qdrs_pkg::CTRL_GEOM_BAD] &
                       ~device_head_select[qdrs_pkg::DH_LBA_BIT]) |
                      (i_cause.out_of_range & ~addr_range_abort);

  // Error image for a failure termination.
  always_comb begin
    next_err = '0;
    next_err.interface_crc_error  = i_cause.ultra_dma & i_cause.crc_error;
    next_err.uncorrectable_data   = i_cause.uncorrectable;
    next_err.media_changed        = media_change_state | i_media_change_seen;
    next_err.address_not_found    = fail_address_not_found;
    next_err.media_change_request = media_change_pending | i_media_change_req;
    next_err.command_aborted      = fail_abort;
    next_err.no_media             = i_no_media;
  end

  // AXI write address and data channels, taken in either order.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_s_awready <= 1'b1;
      o_s_wready  <= 1'b1;
      aw_addr     <= 8'h00;
      w_data      <= 32'h0000_0000;
      w_strb      <= 4'h0;
    end else begin
      if (o_s_awready && i_s_awvalid) begin
        o_s_awready <= 1'b0;
        aw_addr     <= i_s_awaddr;
      end
      if (o_s_wready && i_s_wvalid) begin
        o_s_wready <= 1'b0;
        w_data     <= i_s_wdata;
        w_strb     <= i_s_wstrb;
      end
      if (o_s_bvalid && i_s_bready) begin
        o_s_awready <= 1'b1;
        o_s_wready  <= 1'b1;
      end
    end
  end

  // Write response; unmapped offsets answer with a slave error.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_s_bvalid <= 1'b0;
      o_s_bresp  <= qdrs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      o_s_bvalid <= 1'b1;
      o_s_bresp  <= (aw_addr > qdrs_pkg::OFF_TAGMAP || aw_addr[1:0] != 2'h0) ?
                    qdrs_pkg::RESP_SLVERR : qdrs_pkg::RESP_OKAY;
    end else if (o_s_bvalid && i_s_bready) begin
      o_s_bvalid <= 1'b0;
    end
  end

  // Read channel; data is sampled at the address handshake.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_s_arready <= 1'b1;
      o_s_rvalid  <= 1'b0;
      o_s_rdata   <= 32'h0000_0000;
      o_s_rresp   <= qdrs_pkg::RESP_OKAY;
    end else if (o_s_arready && i_s_arvalid) begin
      o_s_arready <= 1'b0;
      o_s_rvalid  <= 1'b1;
      o_s_rresp   <= qdrs_pkg::RESP_OKAY;
      case (i_s_araddr)
        qdrs_pkg::OFF_ERR_FEAT: o_s_rdata <= {24'h00_0000, error_flags};
        qdrs_pkg::OFF_SECCNT:   o_s_rdata <= {24'h00_0000, sector_count_tag};
        qdrs_pkg::OFF_SECNUM:   o_s_rdata <= {24'h00_0000, sector_number_lba_low};
        qdrs_pkg::OFF_CYLLO:    o_s_rdata <= {24'h00_0000, cylinder_low_lba_mid};
        qdrs_pkg::OFF_CYLHI:    o_s_rdata <= {24'h00_0000, cylinder_high_lba_high};
        qdrs_pkg::OFF_DEVHEAD:  o_s_rdata <= {24'h00_0000, device_head_select};
        qdrs_pkg::OFF_STAT_CMD: o_s_rdata <= {24'h00_0000, status_flags};
        qdrs_pkg::OFF_CTRL:     o_s_rdata <= {24'h00_0000, ctrl};
        qdrs_pkg::OFF_TAGMAP:   o_s_rdata <= tag_map;
        default: begin
          o_s_rdata <= 32'h0000_0000;
          o_s_rresp <= qdrs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (o_s_rvalid && i_s_rready) begin
      o_s_rvalid  <= 1'b0;
      o_s_arready <= 1'b1;
    end
  end

  // Control register; writable at any time, even while busy; it steers acceptance, tag reporting and failure error bits.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= qdrs_pkg::RST_CTRL;
    end else if (wr_lane && aw_addr == qdrs_pkg::OFF_CTRL) begin
      ctrl <= {3'h0, w_data[4:0]};
    end
  end

  // Length register, written through the error offset.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      length_reg <= 8'h00;
    end else if (wr_busy_ok && aw_addr == qdrs_pkg::OFF_ERR_FEAT) begin
      length_reg <= w_data[7:0];
    end
  end

  // Command sequencer: idle accepts, busy waits for release, completion or failure.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= cmd_valid ? ST_BUSY : ST_IDLE;
        ST_BUSY: state <= (i_evt.fail || i_evt.complete || i_evt.release_bus) ? ST_IDLE : ST_BUSY;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Outstanding tags; a tag in use makes a new command with it invalid.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tag_map <= 32'h0000_0000;
    end else if (i_evt.fail) begin
      tag_map <= 32'h0000_0000;
    end else begin
      if (i_evt.complete) begin
        tag_map[i_evt.tag] <= 1'b0;
      end
      // A new tag is entered after the clear so both in one cycle stay correct.
      if (cmd_valid && queuing) begin
        tag_map[host_tag] <= 1'b1;
      end
    end
  end

  // Media change state: a new detection in the reporting cycle wins over the clear.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      media_change_state <= 1'b0;
    end else if (i_media_change_seen) begin
      media_change_state <= 1'b1;
    end else if (i_evt.fail) begin
      media_change_state <= 1'b0;
    end
  end

  // Change request stays until a media access command is accepted.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      media_change_pending <= 1'b0;
    end else if (i_media_change_req) begin
      media_change_pending <= 1'b1;
    end else if (cmd_valid) begin
      media_change_pending <= 1'b0;
    end
  end

  // Task-file image. Host writes land only while idle; the engine images overwrite them.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sector_count_tag       <= 8'h00;
      sector_number_lba_low  <= 8'h00;
      cylinder_low_lba_mid   <= 8'h00;
      cylinder_high_lba_high <= 8'h00;
      device_head_select     <= 8'h00;
      error_flags            <= '0;
    end else if (i_evt.fail) begin
      error_flags            <= next_err;
      sector_count_tag       <= seccnt_byte(report_tag, 1'b0, 1'b1, 1'b1);
      sector_number_lba_low  <= i_cause.fail_addr[7:0];
      cylinder_low_lba_mid   <= i_cause.fail_addr[15:8];
      cylinder_high_lba_high <= i_cause.fail_addr[23:16];
      // Select and mode bits stay as the host wrote them.
      device_head_select     <= {device_head_select[7:4], i_cause.fail_addr[27:24]};
    end else if (i_evt.complete) begin
      error_flags      <= '0;
      sector_count_tag <= seccnt_byte(report_tag, 1'b0, 1'b1, 1'b1);
    end else if (i_evt.release_bus && state == ST_BUSY) begin
      sector_count_tag <= seccnt_byte(report_tag, 1'b1, 1'b0, 1'b0);
    end else if (cmd_abort) begin
      error_flags                 <= '0;
      error_flags.command_aborted <= 1'b1;
      sector_count_tag            <= seccnt_byte(queuing ? host_tag : 5'h00,
                                                 1'b0, 1'b1, 1'b1);
    end else if (wr_busy_ok) begin
      case (aw_addr)
        qdrs_pkg::OFF_SECCNT:  sector_count_tag       <= w_data[7:0];
        qdrs_pkg::OFF_SECNUM:  sector_number_lba_low  <= w_data[7:0];
        qdrs_pkg::OFF_CYLLO:   cylinder_low_lba_mid   <= w_data[7:0];
        qdrs_pkg::OFF_CYLHI:   cylinder_high_lba_high <= w_data[7:0];
        qdrs_pkg::OFF_DEVHEAD: device_head_select     <= w_data[7:0];
        default:               sector_count_tag       <= sector_count_tag;
      endcase
    end
  end

  // Status image; between events only the service bit of a released command can rise until the next command.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      status_flags <= qdrs_pkg::RST_STATUS;
    end else if (i_evt.fail) begin
      status_flags <= status_byte(1'b0, 1'b1, i_cause.fault, i_evt.other_ready, 1'b0,
                                  |next_err);
    end else if (i_evt.complete) begin
      status_flags <= status_byte(1'b0, 1'b1, 1'b0, i_evt.other_ready, 1'b0, 1'b0);
    end else if (i_evt.release_bus && state == ST_BUSY) begin
      status_flags <= status_byte(1'b0, 1'b1, 1'b0, i_evt.other_ready | i_evt.prepared,
                                  1'b0, 1'b0);
    end else if (cmd_abort) begin
      status_flags <= status_byte(1'b0, 1'b1, 1'b0, i_evt.other_ready, 1'b0, 1'b1);
    end else if (cmd_valid) begin
      status_flags <= status_byte(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    end else if (state == ST_IDLE && sector_count_tag[qdrs_pkg::SC_REL_BIT] &&
                 (i_evt.other_ready || i_evt.prepared)) begin
      // Released command turning ready raises service; a command write must not be lost.
      status_flags[4] <= 1'b1;
    end
  end

  // Command issue to the engine, decoding the start address and length.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cmd       <= '0;
      o_cmd_start <= 1'b0;
    end else begin
      o_cmd_start <= cmd_valid;
      if (cmd_valid) begin
        o_cmd.lba_mode   <= device_head_select[qdrs_pkg::DH_LBA_BIT];
        o_cmd.start_addr <= {device_head_select[3:0], cylinder_high_lba_high,
                             cylinder_low_lba_mid, sector_number_lba_low};
        o_cmd.sectors    <= (length_reg == 8'h00) ? qdrs_pkg::FULL_LENGTH :
                            {1'b0, length_reg};
        o_cmd.tag        <= queuing ? host_tag : 5'h00;
      end
    end
  end

  // Queue abort pulse and busy level for the engine.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_queue_abort <= 1'b0;
      o_busy        <= 1'b0;
    end else begin
      o_queue_abort <= i_evt.fail & queuing & (|tag_map);
      o_busy        <= (state == ST_IDLE) ? cmd_valid :
                       ~(i_evt.fail | i_evt.complete | i_evt.release_bus);
    end
  end

endmodule // qdrs_top

// [dv/qdrs_assertions.sv]
// Checker of command start, busy and event timing at the queued DMA read block's ports.
module qdrs_assertions (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_resetn,
  input  wire qdrs_pkg::qdrs_evt_t  i_evt,
  input  wire qdrs_pkg::qdrs_cmd_t  o_cmd,
  input  wire logic                 o_cmd_start,
  input  wire logic                 o_queue_abort,
  input  wire logic                 o_busy,
  input  wire logic                 o_s_rvalid,
  input  wire logic                 i_s_rready
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // A started command carries a length of one to 256 sectors.
  a_length_range: assert property (o_cmd_start |-> o_cmd.sectors != 9'h0 && o_cmd.sectors <= 9'h100)
    else $error("command length out of range");
  a_start_busy: assert property (o_cmd_start |-> o_busy ##1 !o_cmd_start)
    else $error("start pulse without busy");
  a_busy_cause: assert property ($rose(o_busy) |-> o_cmd_start)
    else $error("busy rose without a command");
  a_release_idle: assert property (i_evt.release_bus && o_busy |=> !o_busy)
    else $error("busy kept after release");
  a_complete_idle: assert property (i_evt.complete && o_busy |=> !o_busy)
    else $error("busy kept after completion");
  a_fail_idle: assert property (i_evt.fail && o_busy |=> !o_busy)
    else $error("busy kept after failure");
  a_abort_cause: assert property (o_queue_abort |-> $past(i_evt.fail))
    else $error("queue abort without failure");
  a_read_answer: assert property (o_s_rvalid && i_s_rready |=> !o_s_rvalid)
    else $error("read answer repeated");
  // Main scenarios reached.
  cover property (o_cmd_start);
  cover property (i_evt.release_bus && o_busy);
  cover property (o_queue_abort);
endmodule // qdrs_assertions
bind qdrs_top qdrs_assertions qdrs_assertions_i (.i_clk_sys, .i_resetn, .i_evt, .o_cmd,
  .o_cmd_start, .o_queue_abort, .o_busy, .o_s_rvalid, .i_s_rready);

// [dv/qdrs_engine_model.sv]
// Media engine stand-in that answers each command with a release, completion or failure.
module qdrs_engine_model (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_start,
  input  wire qdrs_pkg::qdrs_cmd_t  i_cmd,
  input  wire logic [1:0]           i_mode,
  input  wire logic                 i_other,
  output qdrs_pkg::qdrs_evt_t       o_evt,
  output qdrs_pkg::qdrs_cause_t     o_cause
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 1000;
  // Failure cause: Ultra DMA CRC error with a device fault at a fixed failing address.
  assign o_cause = '{ultra_dma: 1'b1, crc_error: 1'b1, fault: 1'b1, fail_addr: 28'h1234567,
                     default: 1'b0};
  // Events come four cycles after start; a released command completes much later.
  always @(posedge i_clk_sys) begin
    cnt <= i_start ? 1 : cnt + 1;
    o_evt <= '{release_bus: cnt == 4 && i_mode == 2'h1,
               complete: (cnt == 4 && i_mode == 2'h0) || (cnt == 40 && i_mode == 2'h1),
               fail: cnt == 4 && i_mode == 2'h2, other_ready: i_other, prepared: 1'b0,
               tag: i_cmd.tag};
  end
endmodule // qdrs_engine_model

// [dv/tb.sv]
// Self-checking testbench of the queued DMA read block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, arv = 0, bry = 1, rry = 1, oth = 0, nm = 0, qs = 0;
  logic [7:0]  awa = '0, ara = '0;
  logic [31:0] wd = '0, v;
  logic [1:0]  mode = '0, resp;
  logic        awr, wrd, bv, arr, rv, st, qa, device_busy_flag, mch = 0;
  logic [1:0]  br, rr;
  logic [31:0] rdat;
  qdrs_pkg::qdrs_evt_t   evt;
  qdrs_pkg::qdrs_cause_t cause;
  qdrs_pkg::qdrs_cmd_t   cmd, lc;
  int bad_count = 0, n_checks = 0, cyc = 0;
  qdrs_top qdrs_top_i (.i_clk_sys(clk), .i_resetn(rstn), .i_s_awaddr(awa), .i_s_awvalid(awv),
    .o_s_awready(awr), .i_s_wdata(wd), .i_s_wstrb(4'h1), .i_s_wvalid(wv), .o_s_wready(wrd),
    .o_s_bresp(br), .o_s_bvalid(bv), .i_s_bready(bry), .i_s_araddr(ara), .i_s_arvalid(arv),
    .o_s_arready(arr), .o_s_rdata(rdat), .o_s_rresp(rr), .o_s_rvalid(rv), .i_s_rready(rry),
    .i_evt(evt), .i_cause(cause), .i_media_change_seen(mch), .i_media_change_req(mch),
    .i_no_media(nm), .o_cmd(cmd), .o_cmd_start(st), .o_queue_abort(qa), .o_busy(device_busy_flag));
  qdrs_engine_model qdrs_engine_model_i (.i_clk_sys(clk), .i_start(st), .i_cmd(cmd),
    .i_mode(mode), .i_other(oth), .o_evt(evt), .o_cause(cause));
  // Free-running clock.
  initial forever #5 clk = ~clk;
  // Capture the started command and any queue abort, both too short to catch by polling.
  always @(posedge clk) begin
    if (st) lc <= cmd;
    if (qa) qs <= 1'b1;
  end
  // Watchdog: a hung handshake ends the run as a failure.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write with address and data offered together; ready for the response is always held.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv);
  endtask
  task automatic rd(input logic [7:0] a);
    ara <= a;
    arv <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (!rv);
    v = rdat;
    resp = rr;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, v, e);
  endtask
  task automatic issue(input logic [7:0] c, input logic [7:0] sc, input logic [1:0] m);
    rd(qdrs_pkg::OFF_STAT_CMD);
    chk("ready", v[7:6], 2'h1);
    wr(qdrs_pkg::OFF_CTRL, {24'h0, c});
    wr(qdrs_pkg::OFF_ERR_FEAT, 32'h0);
    wr(qdrs_pkg::OFF_SECCNT, {24'h0, sc});
    wr(qdrs_pkg::OFF_SECNUM, 32'h11);
    wr(qdrs_pkg::OFF_CYLLO, 32'h22);
    wr(qdrs_pkg::OFF_CYLHI, 32'h33);
    wr(qdrs_pkg::OFF_DEVHEAD, 32'h5a);
    wr(qdrs_pkg::OFF_STAT_CMD, {24'h0, qdrs_pkg::CMD_READ_DMA_QUEUED});
    mode <= m;
  endtask
  // Waits for an engine event, then lets the register image settle.
  task automatic wait_evt();
    for (int i = 0; i < 100 && !(evt.complete || evt.fail || evt.release_bus); i++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  task automatic t_regs();
    rc("status", qdrs_pkg::OFF_STAT_CMD, 32'h40);
    rc("ctrl", qdrs_pkg::OFF_CTRL, 32'h07);
    rc("error", qdrs_pkg::OFF_ERR_FEAT, 32'h0);
    rd(8'h24);
    chk("rresp", resp, qdrs_pkg::RESP_SLVERR);
    wr(8'h24, 32'h0);
    chk("bresp", br, qdrs_pkg::RESP_SLVERR);
    $display("test regs done");
  endtask
  task automatic t_complete();
    issue(8'h07, 8'h28, 2'h0);
    wait_evt();
    chk("addr", lc.start_addr, 32'ha332211);
    chk("mode", lc.lba_mode, 1);
    chk("len", lc.sectors, 32'h100);
    chk("tag", lc.tag, 5);
    rc("error", qdrs_pkg::OFF_ERR_FEAT, 32'h0);
    rc("seccnt", qdrs_pkg::OFF_SECCNT, 32'h2b);
    rc("status", qdrs_pkg::OFF_STAT_CMD, 32'h40);
    rc("devhead", qdrs_pkg::OFF_DEVHEAD, 32'h5a);
    $display("test complete done");
  endtask
  task automatic t_release();
    oth <= 1;
    issue(8'h07, 8'h38, 2'h1);
    wait_evt();
    rc("seccnt", qdrs_pkg::OFF_SECCNT, 32'h3c);
    rc("status", qdrs_pkg::OFF_STAT_CMD, 32'h50);
    wait_evt();
    rc("seccnt", qdrs_pkg::OFF_SECCNT, 32'h3b);
    rc("status", qdrs_pkg::OFF_STAT_CMD, 32'h50);
    oth <= 0;
    $display("test release done");
  endtask
  task automatic t_fail();
    nm <= 1;
    issue(8'h07, 8'h48, 2'h2);
    mch <= 1;
    @(posedge clk);
    mch <= 0;
    wait_evt();
    chk("qabort", qs, 1);
    rc("error", qdrs_pkg::OFF_ERR_FEAT, 32'hae);
    rc("status", qdrs_pkg::OFF_STAT_CMD, 32'h61);
    rc("seccnt", qdrs_pkg::OFF_SECCNT, 32'h4b);
    rc("secnum", qdrs_pkg::OFF_SECNUM, 32'h67);
    rc("devhead", qdrs_pkg::OFF_DEVHEAD, 32'h51);
    nm <= 0;
    $display("test fail done");
  endtask
  // Overlap interrupt disabled, then command unsupported without queuing.
  task automatic t_abort();
    logic [7:0] c;
    for (int i = 0; i < 2; i++) begin
      c = i == 0 ? 8'h05 : 8'h02;
      issue(c, 8'h50, 2'h0);
      repeat (3) @(posedge clk);
      rc("error", qdrs_pkg::OFF_ERR_FEAT, 32'h04);
      rc("status", qdrs_pkg::OFF_STAT_CMD, 32'h41);
      rc("seccnt", qdrs_pkg::OFF_SECCNT, c[0] ? 32'h53 : 32'h03);
    end
    $display("test abort done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Reset for twenty cycles, then run every scenario.
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    t_regs();
    t_complete();
    t_release();
    t_fail();
    t_abort();
    finish_test();
  end
endmodule // tb
